// [verilog/psc_pkg.sv]
// Package for the synthesizer control register bank.
// Holds field positions, register codes, widths and timing counts.
package psc_pkg;
	// Word and select field
	localparam int WORD_W        = 32;
	localparam int SEL_W         = 4;
	localparam int NUM_REGS      = 14;
	localparam logic [3:0] SEL_INT   = 4'h0;
	localparam logic [3:0] SEL_PFRAC = 4'h1;
	localparam logic [3:0] SEL_PHASE = 4'h2;
	localparam logic [3:0] SEL_SFRAC = 4'h3;
	localparam logic [3:0] SEL_SMOD  = 4'h4;
	localparam logic [3:0] SEL_REFDV = 4'h5;
	localparam logic [3:0] SEL_FUNC  = 4'h6;
	localparam logic [3:0] SEL_LDBIA = 4'h9;
	localparam logic [3:0] SEL_MUX   = 4'hC;
	// Integer and primary fraction register fields
	localparam int INT_VARMOD_BIT = 28;
	localparam int INT_LSB        = 4;
	localparam int INT_W          = 16;
	localparam int PF_LSB         = 4;
	localparam int PF_W           = 25;
	// Phase register fields
	localparam int PH_EN_BIT      = 31;
	localparam int PH_LSB         = 4;
	localparam int PH_W           = 12;
	// Secondary fraction and modulus
	localparam int F2_LSB         = 4;
	localparam int F2_W           = 24;
	// Reference divider register fields
	localparam int RD_LDMODE_LSB  = 30;
	localparam int RD_CP_LSB      = 25;
	localparam int RD_CP_W        = 4;
	localparam int RD_XBIT_BIT    = 24;
	localparam int RD_HALF_BIT    = 22;
	localparam int RD_DBL_BIT     = 21;
	localparam int RD_RCNT_LSB    = 16;
	localparam int RD_RCNT_W      = 5;
	localparam logic [1:0] LD_NORMAL = 2'h1;
	localparam logic [1:0] LD_TRI    = 2'h0;
	localparam logic [1:0] LD_HIGH   = 2'h2;
	// Function, bias and mux register fields
	localparam int FN_BLEED_LSB   = 24;
	localparam int FN_BLEED_W     = 8;
	localparam int FN_BPOL_BIT    = 23;
	localparam int FN_BEN_BIT     = 22;
	localparam int FN_INTM_BIT    = 20;
	localparam int FN_RLD_BIT     = 18;
	localparam int FN_SDNR_BIT    = 17;
	localparam int FN_CPTPD_BIT   = 16;
	localparam int FN_LWP_LSB     = 8;
	localparam int FN_PD_BIT      = 6;
	localparam int FN_CPT_BIT     = 5;
	localparam int FN_CRST_BIT    = 4;
	localparam int LB_LSB         = 30;
	localparam int MX_LESYNC_BIT  = 20;
	// Timing
	localparam int CLK_NS         = 20;
	localparam int SDRST_NS       = 100;
	localparam int SDRST_CYC      = (SDRST_NS + CLK_NS - 1) / CLK_NS;
	localparam int LOCK_RUN       = 8;
	localparam int REF_LOSS_NS    = 2000;
	localparam int REF_LOSS_CYC   = REF_LOSS_NS / CLK_NS;
endpackage : psc_pkg

// [verilog/psc_shift.sv]
// Three-wire serial receiver: shifts 32 bits MSB first, loads on LE rise.
// Assumes pins already synchronised to i_clk by the caller.
`timescale 1ns/100ps
module psc_shift #(
	parameter int W = 32
) (
	// Clock and reset
	input  wire logic         i_clk,
	input  wire logic         i_rst,
	// Synchronised pins
	input  wire logic         i_sclk,
	input  wire logic         i_sdata,
	input  wire logic         i_le,
	// Word out
	output logic [W-1:0]      o_word,
	output logic              o_load
);
	logic [W-1:0] sr_q, sr_d;
	logic         sclk_q, le_q, load_d;

	always_comb begin
		sr_d   = sr_q;
		load_d = i_le & ~le_q;
		if (i_sclk & ~sclk_q & ~i_le) begin
			sr_d = {sr_q[W-2:0], i_sdata};
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			sr_q   <= '0;
			sclk_q <= 1'b0;
			le_q   <= 1'b0;
			o_load <= 1'b0;
		end else begin
			sr_q   <= sr_d;
			sclk_q <= i_sclk;
			le_q   <= i_le;
			o_load <= load_d;
		end
	end

	assign o_word = sr_q;
endmodule : psc_shift

// [verilog/psc_lockdet.sv]
// Lock detector: counts consecutive comparisons inside a window.
// Assumes phase error magnitude arrives as a same-clock strobe.
`timescale 1ns/100ps
module psc_lockdet #(
	parameter int RUN = psc_pkg::LOCK_RUN
) (
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	// Comparison
	input  wire logic        i_cmp,
	input  wire logic [7:0]  i_err,
	input  wire logic [7:0]  i_window,
	input  wire logic        i_clear,
	// Result
	output logic             o_lock
);
	logic [3:0] run_q, run_d;
	logic       lock_d;

	always_comb begin
		run_d  = run_q;
		lock_d = o_lock;
		if (i_clear) begin
			run_d  = 4'h0;
			lock_d = 1'b0;
		end else if (i_cmp) begin
			if (i_err < i_window) begin
				if (run_q < 4'(RUN)) begin
					run_d = run_q + 4'h1;
				end
				lock_d = (run_q >= 4'(RUN - 1));
			end else begin
				run_d  = 4'h0;
				lock_d = 1'b0;
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			run_q  <= 4'h0;
			o_lock <= 1'b0;
		end else begin
			run_q  <= run_d;
			o_lock <= lock_d;
		end
	end
endmodule : psc_lockdet

// [verilog/psc_regbank.sv]
// Control register bank of the synthesizer, fed by the three-wire link.
// Assumes the comparator inputs are already in i_clk's domain; the serial pins
// and the reference strobe pass the two-stage synchronisers here.
// Notes on behaviour
// - Low four bits select register 0-13
// - Frequency applied only on integer write
// - Integer bit 28 picks variable modulus
// - Phase enable advances phase after integer write
// - Phase advance equals value times 360/4096
// - Secondary fraction ignored under fixed modulus
// - Secondary modulus ignored under fixed modulus
// - Lock pin mode: 01 normal, 00 three-state, else forced
// - Charge pump current code bits 28-25
// - Clear bit 24 adds 26th modulus bit under fixed modulus
// - Bit 22 enables reference halver
// - Doubler enable and 5-bit reference count
// - Bleed magnitude and polarity fields
// - Bleed enable; host uses in fractional
// - Integer mode disables sigma-delta modulator
// - Reference loss drops lock indication
// - Clear bit 17 zeroes fraction on write
// - Bit 16 three-states pump, comparator runs
// - Lock window from precision and bias
// - Power-down keeps registers, clear re-enables
// - Bit 5 three-states charge pump
// - Bit 4 holds dividers in reset
`timescale 1ns/100ps
module psc_regbank (
	// Clock and reset
	input  wire logic         i_clk,
	input  wire logic         i_rst,
	// Three-wire serial pins
	input  wire logic         i_sclk,
	input  wire logic         i_sdata,
	input  wire logic         i_le,
	// Reference and lock comparison
	input  wire logic         i_ref,
	input  wire logic         i_cmp,
	input  wire logic [7:0]   i_phase_err,
	// Frequency setting, applied copies
	output logic [15:0]       o_int_value,
	output logic [24:0]       o_primary_fraction,
	output logic [23:0]       o_secondary_fraction,
	output logic [23:0]       o_secondary_modulus,
	output logic              o_variable_modulus,
	output logic              o_extra_modulus_bit,
	output logic              o_sigma_delta_modulator_en,
	output logic              o_fraction_zero,
	// Phase adjust
	output logic              o_phase_step,
	output logic [11:0]       o_phase_value,
	// Reference path and pump
	output logic              o_reference_halver,
	output logic              o_ref_doubler,
	output logic [4:0]        o_ref_count,
	output logic [3:0]        o_cp_current,
	output logic [7:0]        o_bleed_value,
	output logic              o_bleed_negative,
	output logic              o_bleed_en,
	output logic              o_cp_tristate,
	output logic              o_counter_reset,
	output logic              o_power_down,
	// Lock indicator pin
	output logic              o_lock_indicator_pin,
	output logic              o_lock_indicator_pin_oe
);
	//////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	logic [2:0] pin_m_q, pin_s_q;
	logic       ref_m_q, ref_s_q, ref_l_q;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			pin_m_q <= 3'h0;
			pin_s_q <= 3'h0;
			ref_m_q <= 1'b0;
			ref_s_q <= 1'b0;
			ref_l_q <= 1'b0;
		end else begin
			pin_m_q <= {i_sclk, i_sdata, i_le};
			pin_s_q <= pin_m_q;
			ref_m_q <= i_ref;
			ref_s_q <= ref_m_q;
			ref_l_q <= ref_s_q;
		end
	end

	logic [31:0] word;
	logic        load;

	psc_shift #(.W(psc_pkg::WORD_W)) u_shift (
		.i_clk   (i_clk),
		.i_rst   (i_rst),
		.i_sclk  (pin_s_q[2]),
		.i_sdata (pin_s_q[1]),
		.i_le    (pin_s_q[0]),
		.o_word  (word),
		.o_load  (load)
	);

	//////////////////////////////////////////////////////////////////////////
	// Register file, one word per select code 0-13
	logic [31:0] regs_q [psc_pkg::NUM_REGS];
	logic [3:0]  sel;
	logic        hit;
	assign sel = word[psc_pkg::SEL_W-1:0];
	assign hit = load && (sel < 4'(psc_pkg::NUM_REGS));

	genvar g;
	generate
		for (g = 0; g < psc_pkg::NUM_REGS; g++) begin : g_reg
			logic [31:0] r_d;
			always_comb begin
				r_d = regs_q[g];
				if (hit && sel == 4'(g)) begin
					r_d = word;
				end
			end
			always_ff @(posedge i_clk or posedge i_rst) begin
				if (i_rst) begin
					regs_q[g] <= 32'h0;
				end else begin
					regs_q[g] <= r_d;
				end
			end
		end
	endgenerate

	logic [31:0] r_ph, r_f1, r_rd, r_fn, r_ldb, r_in;
	assign r_in  = regs_q[psc_pkg::SEL_INT];
	assign r_f1  = regs_q[psc_pkg::SEL_PFRAC];
	assign r_ph  = regs_q[psc_pkg::SEL_PHASE];
	assign r_rd  = regs_q[psc_pkg::SEL_REFDV];
	assign r_fn  = regs_q[psc_pkg::SEL_FUNC];
	assign r_ldb = regs_q[psc_pkg::SEL_LDBIA];

	//////////////////////////////////////////////////////////////////////////
	// Applied settings, updated on integer write
	logic        int_wr;
	logic        varmod;
	logic [2:0]  sdr_q, sdr_d;
	logic [11:0] rlost_q, rlost_d;
	logic        ref_edge;
	assign int_wr   = hit && sel == psc_pkg::SEL_INT;
	assign varmod   = word[psc_pkg::INT_VARMOD_BIT];
	assign ref_edge = ref_s_q ^ ref_l_q;

	always_comb begin
		sdr_d = (sdr_q != 3'h0) ? sdr_q - 3'h1 : 3'h0;
		if (int_wr && !r_fn[psc_pkg::FN_SDNR_BIT]) begin
			sdr_d = 3'(psc_pkg::SDRST_CYC);
		end
		rlost_d = ref_edge ? 12'h0 : rlost_q;
		if (!ref_edge && rlost_q < 12'(psc_pkg::REF_LOSS_CYC)) begin
			rlost_d = rlost_q + 12'h1;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_int_value          <= 16'h0;
			o_primary_fraction   <= 25'h0;
			o_secondary_fraction <= 24'h0;
			o_secondary_modulus  <= 24'h0;
			o_variable_modulus   <= 1'b0;
			o_phase_step         <= 1'b0;
			o_phase_value        <= 12'h0;
			o_fraction_zero      <= 1'b0;
			sdr_q                <= 3'h0;
			rlost_q              <= 12'h0;
		end else begin
			o_phase_step <= 1'b0;
			if (int_wr) begin
				o_int_value        <= word[psc_pkg::INT_LSB +: psc_pkg::INT_W];
				o_primary_fraction <= r_f1[psc_pkg::PF_LSB +: psc_pkg::PF_W];
				o_variable_modulus <= varmod;
				// Fixed modulus zeroes the second pair
				o_secondary_fraction <= varmod ?
					regs_q[psc_pkg::SEL_SFRAC][psc_pkg::F2_LSB +: psc_pkg::F2_W] : 24'h0;
				o_secondary_modulus <= varmod ?
					regs_q[psc_pkg::SEL_SMOD][psc_pkg::F2_LSB +: psc_pkg::F2_W] : 24'h0;
				o_phase_step  <= r_ph[psc_pkg::PH_EN_BIT];
				o_phase_value <= r_ph[psc_pkg::PH_LSB +: psc_pkg::PH_W];
			end
			o_fraction_zero <= (sdr_d != 3'h0);
			sdr_q           <= sdr_d;
			rlost_q         <= rlost_d;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Static controls from reference and function registers
	logic        ref_lost;
	logic [7:0]  window;
	logic        lock;
	logic [1:0]  ld_mode;
	assign ref_lost = rlost_q >= 12'(psc_pkg::REF_LOSS_CYC);
	assign ld_mode  = r_rd[psc_pkg::RD_LDMODE_LSB +: 2];
	// Window grows with precision and bias codes
	assign window = 8'h4 + {3'h0, r_fn[psc_pkg::FN_LWP_LSB +: 2], 3'h0}
		+ {4'h0, r_ldb[psc_pkg::LB_LSB +: 2], 2'h0};

	psc_lockdet u_lock (
		.i_clk    (i_clk),
		.i_rst    (i_rst),
		.i_cmp    (i_cmp),
		.i_err    (i_phase_err),
		.i_window (window),
		.i_clear  (o_counter_reset | o_power_down |
			(r_fn[psc_pkg::FN_RLD_BIT] & ref_lost)),
		.o_lock   (lock)
	);

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_extra_modulus_bit        <= 1'b0;
			o_sigma_delta_modulator_en <= 1'b0;
			o_reference_halver         <= 1'b0;
			o_ref_doubler              <= 1'b0;
			o_ref_count                <= 5'h0;
			o_cp_current               <= 4'h0;
			o_bleed_value              <= 8'h0;
			o_bleed_negative           <= 1'b0;
			o_bleed_en                 <= 1'b0;
			o_cp_tristate              <= 1'b0;
			o_counter_reset            <= 1'b0;
			o_power_down               <= 1'b0;
			o_lock_indicator_pin       <= 1'b0;
			o_lock_indicator_pin_oe    <= 1'b0;
		end else begin
			o_extra_modulus_bit <= !r_rd[psc_pkg::RD_XBIT_BIT] && !o_variable_modulus;
			o_sigma_delta_modulator_en <= !r_fn[psc_pkg::FN_INTM_BIT];
			o_reference_halver <= r_rd[psc_pkg::RD_HALF_BIT];
			o_ref_doubler      <= r_rd[psc_pkg::RD_DBL_BIT];
			o_ref_count        <= r_rd[psc_pkg::RD_RCNT_LSB +: psc_pkg::RD_RCNT_W];
			o_cp_current       <= r_rd[psc_pkg::RD_CP_LSB +: psc_pkg::RD_CP_W];
			o_bleed_value      <= r_fn[psc_pkg::FN_BLEED_LSB +: psc_pkg::FN_BLEED_W];
			o_bleed_negative   <= r_fn[psc_pkg::FN_BPOL_BIT];
			o_bleed_en         <= r_fn[psc_pkg::FN_BEN_BIT];
			o_cp_tristate      <= r_fn[psc_pkg::FN_CPT_BIT] | r_fn[psc_pkg::FN_CPTPD_BIT];
			o_counter_reset    <= r_fn[psc_pkg::FN_CRST_BIT];
			o_power_down       <= r_fn[psc_pkg::FN_PD_BIT];
			case (ld_mode)
				psc_pkg::LD_NORMAL: begin
					o_lock_indicator_pin    <= lock;
					o_lock_indicator_pin_oe <= 1'b1;
				end
				psc_pkg::LD_TRI: begin
					o_lock_indicator_pin    <= 1'b0;
					o_lock_indicator_pin_oe <= 1'b0;
				end
				psc_pkg::LD_HIGH: begin
					o_lock_indicator_pin    <= 1'b1;
					o_lock_indicator_pin_oe <= 1'b1;
				end
				default: begin
					o_lock_indicator_pin    <= 1'b0;
					o_lock_indicator_pin_oe <= 1'b1;
				end
			endcase
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Checks
	a_int_only_apply: assert property (@(posedge i_clk) disable iff (i_rst)
		$changed(o_int_value) |-> $past(int_wr)) else $error("int changed without int write");
	a_phase_step_src: assert property (@(posedge i_clk) disable iff (i_rst)
		o_phase_step |-> $past(int_wr) && $past(r_ph[31])) else $error("phase step without cause");
	a_fixed_drop_f2: assert property (@(posedge i_clk) disable iff (i_rst)
		!o_variable_modulus |-> o_secondary_fraction == 24'h0) else $error("fraction2 used in fixed");
	a_fixed_drop_m2: assert property (@(posedge i_clk) disable iff (i_rst)
		!o_variable_modulus |-> o_secondary_modulus == 24'h0) else $error("modulus2 used in fixed");
	a_sd_reset_pulse: assert property (@(posedge i_clk) disable iff (i_rst)
		int_wr && !r_fn[17] |=> ##1 o_fraction_zero [*3]) else $error("fraction zero missing");
	a_no_sd_reset: assert property (@(posedge i_clk) disable iff (i_rst)
		$rose(o_fraction_zero) |-> $past(int_wr) && !$past(r_fn[psc_pkg::FN_SDNR_BIT])) else $error("spurious zero");
	a_ref_loss_drop: assert property (@(posedge i_clk) disable iff (i_rst)
		r_fn[18] && ref_lost && ld_mode == 2'h1 |-> ##[1:3] !o_lock_indicator_pin) else $error("lock kept");
	a_pin_tristate: assert property (@(posedge i_clk) disable iff (i_rst)
		ld_mode == 2'h0 |=> !o_lock_indicator_pin_oe) else $error("pin driven in tristate");
	a_pd_follow: assert property (@(posedge i_clk) disable iff (i_rst)
		$changed(r_fn[6]) |=> o_power_down == $past(r_fn[6])) else $error("power down lag");
	a_cnt_reset: assert property (@(posedge i_clk) disable iff (i_rst)
		o_counter_reset |=> !lock) else $error("lock under counter reset");
	a_range_ignore: assert property (@(posedge i_clk) disable iff (i_rst)
		load && sel > 4'hD |=> $stable(r_fn) && $stable(r_rd) && $stable(r_in)) else $error("select 14-15 stored");
	a_window_drop: assert property (@(posedge i_clk) disable iff (i_rst)
		i_cmp && i_phase_err >= window |=> !lock) else $error("lock kept outside window");
	a_pd_clear: assert property (@(posedge i_clk) disable iff (i_rst)
		o_power_down |=> !lock) else $error("lock kept in power down");
	a_cp_three: assert property (@(posedge i_clk) disable iff (i_rst)
		r_fn[psc_pkg::FN_CPT_BIT] |=> o_cp_tristate) else $error("pump not three-state");
	a_extra_var: assert property (@(posedge i_clk) disable iff (i_rst)
		o_variable_modulus |=> !o_extra_modulus_bit) else $error("extra bit in variable mode");
	a_sdm_follow: assert property (@(posedge i_clk) disable iff (i_rst)
		$changed(r_fn[psc_pkg::FN_INTM_BIT]) |=> o_sigma_delta_modulator_en == !$past(r_fn[psc_pkg::FN_INTM_BIT]))
		else $error("modulator enable lag");

	c_int_write:   cover property (@(posedge i_clk) int_wr);
	c_ref_lost:    cover property (@(posedge i_clk) ref_lost && r_fn[psc_pkg::FN_RLD_BIT]);
	c_phase_step:  cover property (@(posedge i_clk) o_phase_step);
	c_locked:      cover property (@(posedge i_clk) o_lock_indicator_pin && o_lock_indicator_pin_oe);
	c_power_down:  cover property (@(posedge i_clk) $rose(o_power_down));
endmodule : psc_regbank

// [verif/psc_host.sv]
// Host model of the three-wire link: shifts words MSB first, then pulses load.
// Assumes the bench calls send from a falling clock edge, one frame at a time.
`timescale 1ns/100ps
module psc_host (
	// Clock
	input  wire logic i_clk,
	// Serial pins
	output logic      o_sclk,
	output logic      o_sdata,
	output logic      o_le
);
	task automatic hold(input int n);
		repeat (n) @(negedge i_clk);
	endtask : hold
	// Each level held four clocks; select nibble goes out last
	task automatic send(input logic [31:0] w);
		for (int i = 31; i >= 0; i--) begin
			o_sdata = w[i];
			o_sclk = 1'b0;
			hold(4);
			o_sclk = 1'b1;
			hold(4);
		end
		o_sclk = 1'b0;
		o_sdata = ~w[0];
		o_le = 1'b1;
		hold(4);
		o_le = 1'b0;
		hold(8);
	endtask : send
	initial begin
		o_sclk = 1'b0;
		o_sdata = 1'b0;
		o_le = 1'b0;
	end
endmodule : psc_host

// [verif/psc_regbank_bench.sv]
// Bench for the register bank: host model writes words, bench checks outputs.
// Assumes the host model's send returns after the load has settled.
`timescale 1ns/100ps
module psc_regbank_bench;
	logic i_clk, i_rst, i_ref, i_cmp;
	logic [7:0] i_phase_err;
	logic sclk, sdata, le;
	logic [15:0] o_int_value;
	logic [24:0] o_primary_fraction;
	logic [23:0] o_secondary_fraction, o_secondary_modulus;
	logic o_variable_modulus, o_extra_modulus_bit, o_sigma_delta_modulator_en, o_fraction_zero;
	logic o_phase_step, o_reference_halver, o_ref_doubler, o_bleed_negative, o_bleed_en;
	logic o_cp_tristate, o_counter_reset, o_power_down, o_lock_indicator_pin, o_lock_indicator_pin_oe;
	logic [11:0] o_phase_value;
	logic [4:0] o_ref_count;
	logic [3:0] o_cp_current;
	logic [7:0] o_bleed_value;
	logic [1:0] mm;
	int n_fail, tests_run, n_step, n_fz;
	logic [31:0] w6[6] = '{32'hA5C2_0006, 32'h0013_0006, 32'h0002_0026, 32'h0002_0016, 32'h0002_0046,
		32'h0002_0006};
	logic [13:0] e6[6] = '{14'h2971, 14'h0008, 14'h0009, 14'h0005, 14'h0003, 14'h0001};

	psc_host host (.i_clk(i_clk), .o_sclk(sclk), .o_sdata(sdata), .o_le(le));

	psc_regbank uut (.i_clk, .i_rst, .i_sclk(sclk), .i_sdata(sdata), .i_le(le), .i_ref, .i_cmp,
		.i_phase_err, .o_int_value, .o_primary_fraction, .o_secondary_fraction, .o_secondary_modulus,
		.o_variable_modulus, .o_extra_modulus_bit, .o_sigma_delta_modulator_en, .o_fraction_zero,
		.o_phase_step, .o_phase_value, .o_reference_halver, .o_ref_doubler, .o_ref_count, .o_cp_current,
		.o_bleed_value, .o_bleed_negative, .o_bleed_en, .o_cp_tristate, .o_counter_reset, .o_power_down,
		.o_lock_indicator_pin, .o_lock_indicator_pin_oe);

	////////////////////////////////////////////////////////////////////////////
	initial begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end

	always @(posedge i_clk) begin
		if (o_phase_step === 1'b1) n_step++;
		if (o_fraction_zero === 1'b1) n_fz++;
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic tick(input int n);
		repeat (n) @(negedge i_clk);
	endtask : tick
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic chk_n(input int got, input int exp);
		chk(32'(got), 32'(exp));
	endtask : chk_n
	task automatic wr(input logic [31:0] w);
		host.send(w);
	endtask : wr
	// Reference edge, then one comparison strobe
	task automatic cmp(input logic [7:0] e, input int n);
		repeat (n) begin
			i_ref = ~i_ref;
			tick(3);
			i_phase_err = e;
			i_cmp = 1'b1;
			tick(1);
			i_cmp = 1'b0;
		end
		tick(3);
	endtask : cmp
	task automatic done(input string s);
		$display("test %s done", s);
	endtask : done
	task automatic final_report;
		$display("checks=%0d failures=%0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : final_report

	initial begin
		#1_000_000;
		n_fail++;
		final_report();
	end

	////////////////////////////////////////////////////////////////////////////
	initial begin
		i_rst = 1'b1;
		i_ref = 1'b0;
		i_cmp = 1'b0;
		i_phase_err = 8'h00;
		tick(5);
		i_rst = 1'b0;
		tick(2);
		chk({o_lock_indicator_pin_oe, o_power_down, o_int_value}, 32'h0);
		done("reset");
		// Fixed modulus: staged fields wait for the integer write
		wr(32'h0123_4561);
		wr(32'h8000_2002);
		wr(32'h0ABC_DEF3);
		wr(32'h0000_0644);
		chk(o_primary_fraction, 32'h0);
		chk(o_phase_value, 32'h0);
		n_step = 0;
		n_fz = 0;
		wr(32'h0000_0170);
		chk(o_int_value, 32'h17);
		chk(o_primary_fraction, 32'h0123456);
		chk(o_variable_modulus, 32'h0);
		chk(o_secondary_fraction, 32'h0);
		chk(o_secondary_modulus, 32'h0);
		chk_n(n_step, 1);
		chk(o_phase_value, 32'h200);
		chk_n(n_fz, 5);
		done("fixed");
		// Reference setup, every lock pin mode
		for (int m = 0; m < 4; m++) begin
			mm = 2'(m);
			wr({mm, 1'b0, 4'(m + 9), mm[0], 1'b0, mm[1], ~mm[1], 5'(m * 9 + 4), 12'h000, 4'h5});
			chk({o_cp_current, o_extra_modulus_bit, o_reference_halver, o_ref_doubler, o_ref_count},
				{4'(m + 9), ~mm[0], mm[1], ~mm[1], 5'(m * 9 + 4)});
			chk({o_lock_indicator_pin_oe, o_lock_indicator_pin}, {mm != 2'h0, mm == 2'h2});
		end
		done("refdiv");
		// Variable modulus, modulator reset off
		wr(32'h0002_0006);
		n_step = 0;
		n_fz = 0;
		wr(32'h1000_1FF0);
		chk(o_variable_modulus, 32'h1);
		chk(o_secondary_fraction, 32'hABCDEF);
		chk(o_secondary_modulus, 32'h64);
		chk(o_extra_modulus_bit, 32'h0);
		chk_n(n_fz, 0);
		chk_n(n_step, 1);
		done("variable");
		// Function register fields, load sync cleared first
		wr(32'h0000_000C);
		for (int k = 0; k < 6; k++) begin
			wr(w6[k]);
			chk({o_bleed_value, o_bleed_negative, o_bleed_en, o_cp_tristate, o_counter_reset, o_power_down,
				o_sigma_delta_modulator_en}, e6[k]);
			chk(o_int_value, 32'h1FF);
		end
		done("function");
		// Select codes 14 and 15 change nothing
		wr(32'hFFFF_FFFF);
		wr(32'hFFFF_FFFE);
		chk({o_bleed_value, o_cp_current, o_int_value}, 32'h0C01FF);
		done("select");
		// Lock window 12, then with bias 16, then reference loss
		wr(32'h4000_0005);
		wr(32'h0006_0106);
		cmp(8'h0B, 8);
		chk({o_lock_indicator_pin_oe, o_lock_indicator_pin}, 32'h3);
		cmp(8'h0C, 1);
		chk(o_lock_indicator_pin, 32'h0);
		wr(32'h4000_0009);
		cmp(8'h0F, 8);
		chk(o_lock_indicator_pin, 32'h1);
		tick(120);
		chk(o_lock_indicator_pin, 32'h0);
		done("lock");
		final_report();
	end
endmodule : psc_regbank_bench
